// *** core/dpl_ctl.sv ***
// Controller end: makes CK, issues commands, drives and takes data.
// Assumes the memory end samples pins with a two-stage sampler.
`timescale 1ns/100ps
`include "dpl_map.svh"

// Write data buffer with registered ready
module dpl_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = `DPL_FIFO_DEPTH
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_vld_i,
   output logic                  in_rdy_o,
   output logic [WIDTH-1:0]      out_data_o,
   output logic                  out_vld_o,
   input  wire logic             out_rdy_i
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wp_r;
   logic [PW-1:0]    rp_r;
   logic [PW:0]      cnt_r;
   logic [PW:0]      cnt_nxt;
   logic             rdy_r;
   logic             push;
   logic             pop;

   assign push    = in_vld_i && rdy_r;
   assign pop     = out_rdy_i && cnt_r != '0;
   assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         rdy_r <= 1'h1;
      end
      else
      begin
         wp_r  <= wp_r + PW'(push);
         rp_r  <= rp_r + PW'(pop);
         cnt_r <= cnt_nxt;
         rdy_r <= cnt_nxt != (PW+1)'(DEPTH);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wp_r] <= in_data_i;
   end

   assign in_rdy_o   = rdy_r;
   assign out_vld_o  = cnt_r != '0;
   assign out_data_o = mem[rp_r];
endmodule : dpl_fifo

module dpl_ctl
   import dpl_pkg::*;
#(
   parameter int BURST_LEN  = `DPL_BURST_LEN,
   parameter int CK_HALF    = `DPL_CK_HALF_CYC,
   parameter int FIFO_DEPTH = `DPL_FIFO_DEPTH
)
(
   input  wire logic        SYS_CLK_I,
   input  wire logic        SYS_RST_I,
   dpl_if.ctl               PIN,
   input  wire logic        REQ_VLD_I,
   input  wire dpl_req_t    REQ_CMD_I,
   input  wire logic [1:0]  REQ_BANK_I,
   input  wire logic [12:0] REQ_ADDR_I,
   output logic             REQ_ACK_O,
   input  wire logic        SUSPEND_I,
   input  wire logic [15:0] WDATA_I,
   input  wire logic [1:0]  WMASK_I,
   input  wire logic        WDATA_VLD_I,
   output logic             WDATA_RDY_O,
   output logic [15:0]      RDATA_O,
   output logic             RDATA_VLD_O
);
   logic [7:0]  div_r;
   logic        ck_r;
   logic        tick;
   logic        fall;
   logic        take;
   dpl_ctl_st_t st_r;
   dpl_req_t    kind_r;
   logic        ack_r;
   logic [2:0]  code_r;
   logic        cs_n_r;
   logic        cke_r;
   logic [1:0]  ba_r;
   logic [12:0] addr_r;
   logic [17:0] f_data;
   logic        f_vld;
   logic        pop;
   logic        loaded_r;
   logic [7:0]  tmr_r;
   logic [3:0]  beat_r;
   logic [15:0] dq_r;
   logic [1:0]  dm_r;
   logic        oe_r;
   logic [1:0]  dqs_r;
   logic [2:0]  rs1_r;
   logic [2:0]  rs2_r;
   logic        rdqs_d_r;
   logic [15:0] rdq1_r;
   logic [15:0] rdq2_r;
   logic [15:0] rdata_r;
   logic        rvld_r;

   dpl_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) dpl_fifo_inst
   (
      .clk_i      (SYS_CLK_I),
      .rst_i      (SYS_RST_I),
      .in_data_i  ({WMASK_I, WDATA_I}),
      .in_vld_i   (WDATA_VLD_I),
      .in_rdy_o   (WDATA_RDY_O),
      .out_data_o (f_data),
      .out_vld_o  (f_vld),
      .out_rdy_i  (pop)
   );

   // CK from a divider; commands change on its falling edge
   assign tick = div_r == 8'(CK_HALF - 1);
   assign fall = tick & ck_r;
   assign take = st_r == CS_IDLE && fall && REQ_VLD_I
                 && (REQ_CMD_I != REQ_WRITE || f_vld);

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         div_r <= 8'h00;
         ck_r  <= 1'h0;
      end
      else
      begin
         div_r <= tick ? 8'h00 : div_r + 8'h01;
         if (tick)
            ck_r <= ~ck_r;
      end
   end

   // Command pins, held for one CK period
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         cs_n_r <= `DPL_RST_CMD_N;
         code_r <= 3'h7;
         ba_r   <= 2'h0;
         addr_r <= 13'h0000;
         cke_r  <= 1'h1;
         kind_r <= REQ_ACT;
         ack_r  <= 1'h0;
      end
      else
      begin
         ack_r <= take;
         if (fall)
            cke_r <= ~SUSPEND_I;
         if (take)
         begin
            cs_n_r <= 1'h0;
            code_r <= dpl_encode(REQ_CMD_I);
            ba_r   <= REQ_BANK_I;                               // [RULE13]
            addr_r <= REQ_ADDR_I;                               // [RULE14]
            kind_r <= REQ_CMD_I;
         end
         else if (fall)
         begin
            cs_n_r <= 1'h1;
            code_r <= 3'h7;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
         st_r <= CS_IDLE;
      else
      begin
         unique case (st_r)
            CS_IDLE:
               if (take)
                  st_r <= CS_CMD;
            CS_CMD:
               if (fall)
                  st_r <= kind_r == REQ_WRITE ? CS_WRITE
                        : kind_r == REQ_READ  ? CS_READ : CS_IDLE;
            CS_WRITE:
               if (!loaded_r && beat_r == 4'(BURST_LEN))
                  st_r <= CS_IDLE;
            CS_READ:
               if (beat_r == 4'(BURST_LEN))
                  st_r <= CS_IDLE;
         endcase
      end
   end

   // Write beats: load word, mid-beat strobe edge; stalls on empty
   assign pop = st_r == CS_WRITE && !loaded_r
                && beat_r != 4'(BURST_LEN) && f_vld;

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I || st_r == CS_CMD)
      begin
         loaded_r <= 1'h0;
         tmr_r    <= 8'h00;
         beat_r   <= 4'h0;
         dqs_r    <= 2'h0;
      end
      else if (pop)
      begin
         loaded_r <= 1'h1;
         {dm_r, dq_r} <= f_data;
      end
      else if (loaded_r)
      begin
         tmr_r <= tmr_r + 8'h01;
         if (tmr_r == 8'(CK_HALF / 2 - 1))
         begin
            dqs_r  <= ~dqs_r;
            beat_r <= beat_r + 4'h1;
         end
         if (tmr_r == 8'(CK_HALF - 1))
         begin
            loaded_r <= 1'h0;
            tmr_r    <= 8'h00;
         end
      end
      else if (st_r == CS_READ && rs2_r[0] != rdqs_d_r)
         beat_r <= beat_r + 4'h1;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
         oe_r <= 1'h0;
      else
         oe_r <= st_r == CS_WRITE && (loaded_r || pop);
   end

   // Read capture on the low-lane strobe edges
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         rs1_r    <= 3'h0;
         rs2_r    <= 3'h0;
         rdqs_d_r <= 1'h0;
         rdq1_r   <= 16'h0000;
         rdq2_r   <= 16'h0000;
         rdata_r  <= 16'h0000;
         rvld_r   <= 1'h0;
      end
      else
      begin
         rs1_r    <= {1'h0, PIN.dqs};
         rs2_r    <= rs1_r;
         rdqs_d_r <= rs2_r[0];
         rdq1_r   <= PIN.dq;
         rdq2_r   <= rdq1_r;
         rvld_r   <= st_r == CS_READ && rs2_r[0] != rdqs_d_r;
         if (st_r == CS_READ && rs2_r[0] != rdqs_d_r)
            rdata_r <= rdq2_r;
      end
   end

   assign PIN.ck         = ck_r;
   assign PIN.cke        = cke_r;
   assign PIN.cs_n       = cs_n_r;
   assign {PIN.ras_n, PIN.cas_n, PIN.we_n} = code_r;
   assign PIN.ba         = ba_r;
   assign PIN.addr       = addr_r;
   assign PIN.dm         = dm_r;
   assign PIN.dq_ctl     = dq_r;
   assign PIN.dq_ctl_oe  = oe_r;
   assign PIN.dqs_ctl    = dqs_r;
   assign PIN.dqs_ctl_oe = oe_r;
   assign REQ_ACK_O      = ack_r;
   assign RDATA_O        = rdata_r;
   assign RDATA_VLD_O    = rvld_r;
endmodule : dpl_ctl

// *** core/dpl_map.svh ***
// Constants of the DDR pin-level command and data lanes.
// Assumes inclusion by bare name from the controller end and memory end design files.
`ifndef DPL_MAP_SVH
`define DPL_MAP_SVH

`define DPL_SYS_PERIOD_NS 5
`define DPL_CK_PERIOD_NS  80
`define DPL_CK_HALF_CYC   (`DPL_CK_PERIOD_NS / (2 * `DPL_SYS_PERIOD_NS))
`define DPL_BURST_LEN     2
`define DPL_COL_BITS      4
`define DPL_FIFO_DEPTH    32
`define DPL_AUTO_PRE_BIT  10
`define DPL_ADDR_W        13
`define DPL_RST_CMD_N     1'h1

`endif

// *** core/dpl_pkg.sv ***
// Types, command decoding for the memory end and encoding for the controller end of the DDR pin link.
// Assumes nothing beyond a SystemVerilog compiler.
package dpl_pkg;

   typedef enum logic [2:0]
   {
      CMD_NONE,
      CMD_ACT,
      CMD_CLOSE,
      CMD_READ,
      CMD_WRITE,
      CMD_OTHER
   } dpl_cmd_t;

   typedef enum logic [1:0]
   {
      REQ_ACT,
      REQ_CLOSE,
      REQ_READ,
      REQ_WRITE
   } dpl_req_t;

   typedef enum logic [1:0]
   {
      DS_IDLE,
      DS_READ,
      DS_WRITE
   } dpl_dev_st_t;

   typedef enum logic [1:0]
   {
      CS_IDLE,
      CS_CMD,
      CS_WRITE,
      CS_READ
   } dpl_ctl_st_t;

   function automatic dpl_cmd_t dpl_decode(input logic cs_n,
                                           input logic ras_n,
                                           input logic cas_n,
                                           input logic we_n);
      dpl_cmd_t c;
      c = CMD_OTHER;
      if (cs_n)
         c = CMD_NONE;
      else if (!ras_n && cas_n)
         c = we_n ? CMD_ACT : CMD_CLOSE;
      else if (ras_n && !cas_n)
         c = we_n ? CMD_READ : CMD_WRITE;
      else if (ras_n && cas_n)
         c = CMD_NONE;
      return c;
   endfunction : dpl_decode

   // Pin levels {ras_n, cas_n, we_n} for a request
   function automatic logic [2:0] dpl_encode(input dpl_req_t r);
      logic [2:0] p;
      p = 3'h7;
      unique case (r)
         REQ_ACT:   p = 3'h3;
         REQ_CLOSE: p = 3'h2;
         REQ_READ:  p = 3'h5;
         REQ_WRITE: p = 3'h4;
      endcase
      return p;
   endfunction : dpl_encode

endpackage : dpl_pkg

// *** core/dpl_if.sv ***
// Pin bundle joining the memory end and the controller end.
// Resolves the shared data and strobe wires; undriven reads as zero.
`timescale 1ns/100ps
interface dpl_if;
   logic        ck;
   logic        cke;
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [1:0]  ba;
   logic [12:0] addr;
   logic [1:0]  dm;
   logic [15:0] dq_dev;
   logic        dq_dev_oe;
   logic [15:0] dq_ctl;
   logic        dq_ctl_oe;
   logic [15:0] dq;
   logic [1:0]  dqs_dev;
   logic        dqs_dev_oe;
   logic [1:0]  dqs_ctl;
   logic        dqs_ctl_oe;
   logic [1:0]  dqs;

   assign dq  = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : 16'h0000);
   assign dqs = dqs_dev_oe ? dqs_dev : (dqs_ctl_oe ? dqs_ctl : 2'h0);

   modport dev
   (
      input  ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq, dqs,
      output dq_dev, dq_dev_oe, dqs_dev, dqs_dev_oe
   );

   modport ctl
   (
      input  dq, dqs,
      output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
      output dq_ctl, dq_ctl_oe, dqs_ctl, dqs_ctl_oe
   );
endinterface : dpl_if

// *** core/dpl_dev.sv ***
// Memory end: decodes commands and moves data on the DDR pins.
// Assumes all pins arrive asynchronously and pass a two-stage sampler.
// Behaviour
// [RULE1] Decode commands only with chip select low
// [RULE2] Command is chip select, RAS, CAS, WE
// [RULE3] RAS low, CAS high: WE picks row command
// [RULE4] WE high opens the selected bank
// [RULE5] WE low closes the selected bank
// [RULE6] RAS high, CAS low starts column access
// [RULE7] Column access: WE high reads, low writes
// [RULE8] Each byte lane has its own strobe
// [RULE9] Read strobes edge-aligned; write strobes from controller
// [RULE10] Masked write beats are not stored
// [RULE11] Each mask gates only its own byte
// [RULE12] Data moves on both strobe edges
// [RULE13] Controller gives bank select with commands
// [RULE14] Controller gives row/column address, bit 10 autoclose
// [RULE15] Clock enable low suspends from next cycle
// [RULE16] Only the transmitting side drives data, strobes
`timescale 1ns/100ps
`include "dpl_map.svh"
module dpl_dev
   import dpl_pkg::*;
#(
   parameter int BURST_LEN = `DPL_BURST_LEN,
   parameter int BEAT_CYC  = `DPL_CK_HALF_CYC,
   parameter int COL_BITS  = `DPL_COL_BITS
)
(
   input  wire logic       SYS_CLK_I,
   input  wire logic       SYS_RST_I,
   dpl_if.dev              PIN,
   output logic [3:0]      BANK_OPEN_O,
   output dpl_cmd_t        CMD_O,
   output logic            CMD_STB_O,
   output logic            SUSPENDED_O
);

   localparam int AW    = 2 + COL_BITS;
   localparam int DEPTH = 1 << AW;
   localparam int SW    = 41;
   localparam int APB   = `DPL_AUTO_PRE_BIT;

   logic [SW-1:0]   s1_r;
   logic [SW-1:0]   s2_r;
   logic            ck_s;
   logic            cke_s;
   logic            cs_n_s;
   logic            ras_n_s;
   logic            cas_n_s;
   logic            we_n_s;
   logic [1:0]      ba_s;
   logic [12:0]     addr_s;
   logic [1:0]      dm_s;
   logic [1:0]      dqs_s;
   logic [15:0]     dq_s;
   logic            ck_d_r;
   logic [1:0]      dqs_d_r;
   logic            ck_rise;
   logic            cmd_vld;
   dpl_cmd_t        cmd;
   logic            col_go;
   logic            susp_r;
   logic [3:0]      open_r;
   dpl_dev_st_t     st_r;
   logic [1:0]      bank_r;
   logic [COL_BITS-1:0] col_r;
   logic            ap_r;
   logic [3:0]      beat_r;
   logic [7:0]      tmr_r;
   logic            beat_tick;
   logic            burst_end;
   logic [1:0]      wr_done;
   logic [15:0]     rd_word;
   logic [15:0]     dq_o_r;
   logic            dq_oe_r;
   logic [1:0]      dqs_o_r;
   logic            dqs_oe_r;
   dpl_cmd_t        cmd_r;
   logic            cmd_stb_r;

   function automatic logic [AW-1:0] mem_idx(input logic [1:0] b,
                                             input logic [COL_BITS-1:0] c,
                                             input logic [3:0] n);
      logic [COL_BITS-1:0] s;
      s = c + COL_BITS'(n);
      return {b, s};
   endfunction : mem_idx

   // Two-stage sampler for every pin
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         s1_r <= '0;
         s2_r <= '0;
      end
      else
      begin
         s1_r <= {PIN.ck, PIN.cke, PIN.cs_n, PIN.ras_n, PIN.cas_n,
                  PIN.we_n, PIN.ba, PIN.addr, PIN.dm, PIN.dqs, PIN.dq};
         s2_r <= s1_r;
      end
   end

   assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s,
           dm_s, dqs_s, dq_s} = s2_r;

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         ck_d_r  <= 1'h0;
         dqs_d_r <= 2'h0;
      end
      else
      begin
         ck_d_r  <= ck_s;
         dqs_d_r <= dqs_s;
      end
   end

   assign ck_rise = ck_s & ~ck_d_r;                               // [RULE2]
   assign cmd_vld = ck_rise & ~susp_r;                            // [RULE15]
   assign cmd     = dpl_decode(cs_n_s, ras_n_s, cas_n_s, we_n_s); // [RULE1]
   assign col_go  = cmd_vld && (cmd == CMD_READ || cmd == CMD_WRITE)
                    && st_r == DS_IDLE && open_r[ba_s];           // [RULE6]

   // Clock enable sampled on each rise, effective from the next
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
         susp_r <= 1'h0;
      else if (ck_rise)
         susp_r <= ~cke_s;                                        // [RULE15]
   end

   // Bank open/closed tracking
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
         open_r <= 4'h0;
      else if (cmd_vld && cmd == CMD_ACT)
         open_r[ba_s] <= 1'h1;                                    // [RULE4]
      else if (cmd_vld && cmd == CMD_CLOSE)
      begin
         if (addr_s[APB])
            open_r <= 4'h0;
         else
            open_r[ba_s] <= 1'h0;                                 // [RULE5]
      end
      else if (burst_end && ap_r)
         open_r[bank_r] <= 1'h0;
   end

   assign beat_tick = ~susp_r && tmr_r == 8'(BEAT_CYC - 1);
   assign burst_end = (st_r == DS_READ && beat_tick
                       && beat_r == 4'(BURST_LEN))
                      || (st_r == DS_WRITE && &wr_done);

   // Access sequencing
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         st_r   <= DS_IDLE;
         bank_r <= 2'h0;
         col_r  <= '0;
         ap_r   <= 1'h0;
      end
      else if (col_go)
      begin
         st_r   <= (cmd == CMD_READ) ? DS_READ : DS_WRITE;        // [RULE7]
         bank_r <= ba_s;
         col_r  <= addr_s[COL_BITS-1:0];
         ap_r   <= addr_s[APB];
      end
      else if (burst_end)
         st_r <= DS_IDLE;
   end

   // Read beat timer, frozen while suspended
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I || col_go)
      begin
         tmr_r  <= 8'h00;
         beat_r <= 4'h0;
      end
      else if (st_r == DS_READ && !susp_r)
      begin
         tmr_r <= beat_tick ? 8'h00 : tmr_r + 8'h01;
         if (beat_tick)
            beat_r <= beat_r + 4'h1;
      end
   end

   // Read drive: preamble, one beat per strobe edge, postamble
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         dq_o_r   <= 16'h0000;
         dq_oe_r  <= 1'h0;
         dqs_o_r  <= 2'h0;
         dqs_oe_r <= 1'h0;
      end
      else if (col_go && cmd == CMD_READ)
      begin
         dq_oe_r  <= 1'h1;                                        // [RULE16]
         dqs_oe_r <= 1'h1;
         dqs_o_r  <= 2'h0;
      end
      else if (burst_end && st_r == DS_READ)
      begin
         dq_oe_r  <= 1'h0;                                        // [RULE16]
         dqs_oe_r <= 1'h0;
      end
      else if (st_r == DS_READ && beat_tick)
      begin
         dq_o_r  <= rd_word;                                      // [RULE9]
         dqs_o_r <= ~dqs_o_r;                                     // [RULE12]
      end
   end

   // Byte lanes: own strobe, own mask, own storage
   for (genvar i = 0; i < 2; i++)
   begin : g_lane
      logic [7:0] mem [DEPTH];
      logic [3:0] wcnt_r;
      logic       edge_w;
      logic       take_w;

      assign edge_w     = dqs_s[i] ^ dqs_d_r[i];                  // [RULE8]
      assign wr_done[i] = (wcnt_r == 4'(BURST_LEN));
      assign take_w     = st_r == DS_WRITE && edge_w && !wr_done[i];
      assign rd_word[8*i +: 8] = mem[mem_idx(bank_r, col_r, beat_r)];

      always_ff @(posedge SYS_CLK_I)
      begin
         if (SYS_RST_I || col_go)
            wcnt_r <= 4'h0;
         else if (take_w)
            wcnt_r <= wcnt_r + 4'h1;                              // [RULE12]
      end

      always_ff @(posedge SYS_CLK_I)
      begin
         if (take_w && !dm_s[i])                                  // [RULE10]
            mem[mem_idx(bank_r, col_r, wcnt_r)] <= dq_s[8*i +: 8]; // [RULE11]
      end
   end

   // Decoded command report
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         cmd_r     <= CMD_NONE;
         cmd_stb_r <= 1'h0;
      end
      else
      begin
         cmd_stb_r <= cmd_vld && cmd != CMD_NONE;                 // [RULE1]
         if (cmd_vld && cmd != CMD_NONE)
            cmd_r <= cmd;                                         // [RULE3]
      end
   end

   assign PIN.dq_dev     = dq_o_r;
   assign PIN.dq_dev_oe  = dq_oe_r;
   assign PIN.dqs_dev    = dqs_o_r;
   assign PIN.dqs_dev_oe = dqs_oe_r;
   assign BANK_OPEN_O    = open_r;
   assign CMD_O          = cmd_r;
   assign CMD_STB_O      = cmd_stb_r;
   assign SUSPENDED_O    = susp_r;

endmodule : dpl_dev

// *** dv/dpl_asserts.sv ***
// Checker for the pin link between the memory and controller ends.
// Assumes the bench places it beside the pin interface, default params.
`timescale 1ns/100ps
module dpl_asserts
   import dpl_pkg::*;
(
   input logic       SYS_CLK_I,
   input logic       SYS_RST_I,
   input logic       ck,
   input logic       cke,
   input logic       cs_n,
   input logic       ras_n,
   input logic       cas_n,
   input logic       we_n,
   input logic [1:0] dm,
   input logic       dq_dev_oe,
   input logic       dqs_dev_oe,
   input logic       dq_ctl_oe,
   input logic       dqs_ctl_oe,
   input dpl_cmd_t   CMD_O,
   input logic       CMD_STB_O,
   input logic       SUSPENDED_O
);
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   // Code sampled at a CK rise, previous rise 16 cycles back
   property decode_p(logic [2:0] code, dpl_cmd_t c);
      $rose(ck) && !cs_n && $past(cke, 16) && {ras_n, cas_n, we_n} == code
         |-> ##[3:4] CMD_STB_O && CMD_O == c;
   endproperty

   chk_no_data_fight:
      assert property (!(dq_dev_oe && dq_ctl_oe))
      else $error("Data lines driven by both ends");
   chk_no_strobe_fight:
      assert property (!(dqs_dev_oe && dqs_ctl_oe))
      else $error("Strobe lines driven by both ends");
   chk_read_strobe_drive:
      assert property (dq_dev_oe |-> dqs_dev_oe)
      else $error("Read data driven without strobes");
   chk_cmd_at_fall:
      assert property ($changed({cs_n, ras_n, cas_n, we_n}) |-> $fell(ck))
      else $error("Command pins moved away from a CK fall");
   chk_deselect_ignored:
      assert property ($rose(ck) && cs_n |-> ##3 !CMD_STB_O ##1 !CMD_STB_O)
      else $error("Command decoded while deselected");
   chk_act_decode:
      assert property (decode_p(3'h3, CMD_ACT))
      else $error("Row activation not decoded");
   chk_close_decode:
      assert property (decode_p(3'h2, CMD_CLOSE))
      else $error("Bank close not decoded");
   chk_read_decode:
      assert property (decode_p(3'h5, CMD_READ))
      else $error("Read not decoded");
   chk_write_decode:
      assert property (decode_p(3'h4, CMD_WRITE))
      else $error("Write not decoded");
   chk_suspend_seen:
      assert property ($rose(ck) && !cke |-> ##[2:5] SUSPENDED_O)
      else $error("Clock enable low not taken as suspend");

   cov_read_burst: cover property ($rose(dq_dev_oe));
   cov_write_burst: cover property ($rose(dq_ctl_oe));
   cov_masked_beat: cover property (dq_ctl_oe && dm != 2'h0);
endmodule : dpl_asserts

// *** dv/tb_ddr_command_and_data_lane_pins.sv ***
// Bench joining the memory and controller ends over the pin interface.
// Assumes default parameters: CK of 16 cycles, bursts of two words.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
   mismatches++; $display("Error %s expected %h seen %h", nm, ex, got); \
   end end
module tb_ddr_command_and_data_lane_pins
   import dpl_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        req_vld = 1'b0;
   dpl_req_t    req_cmd = REQ_ACT;
   logic [1:0]  req_bank = 2'h0;
   logic [12:0] req_addr = 13'h0000;
   logic        suspend = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic [1:0]  wmask = 2'h0;
   logic        wvld = 1'b0;
   logic        req_ack;
   logic        wrdy;
   logic        rvld;
   logic        cmd_stb;
   logic        susp;
   logic [15:0] rdata;
   logic [3:0]  bank_open;
   dpl_cmd_t    cmd_o;
   int          mismatches = 0;
   int          checked = 0;
   int          n;

   always #2.5 clk = ~clk;

   dpl_if pins();
   dpl_dev dpl_dev_inst(.SYS_CLK_I(clk), .SYS_RST_I(rst), .PIN(pins),
      .BANK_OPEN_O(bank_open), .CMD_O(cmd_o), .CMD_STB_O(cmd_stb),
      .SUSPENDED_O(susp));
   dpl_ctl dpl_ctl_inst(.SYS_CLK_I(clk), .SYS_RST_I(rst), .PIN(pins),
      .REQ_VLD_I(req_vld), .REQ_CMD_I(req_cmd), .REQ_BANK_I(req_bank),
      .REQ_ADDR_I(req_addr), .REQ_ACK_O(req_ack), .SUSPEND_I(suspend),
      .WDATA_I(wdata), .WMASK_I(wmask), .WDATA_VLD_I(wvld),
      .WDATA_RDY_O(wrdy), .RDATA_O(rdata), .RDATA_VLD_O(rvld));
   dpl_asserts dpl_asserts_inst(.SYS_CLK_I(clk), .SYS_RST_I(rst),
      .ck(pins.ck), .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
      .cas_n(pins.cas_n), .we_n(pins.we_n), .dm(pins.dm),
      .dq_dev_oe(pins.dq_dev_oe), .dqs_dev_oe(pins.dqs_dev_oe),
      .dq_ctl_oe(pins.dq_ctl_oe), .dqs_ctl_oe(pins.dqs_ctl_oe),
      .CMD_O(cmd_o), .CMD_STB_O(cmd_stb), .SUSPENDED_O(susp));

   task automatic give_verdict;
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   // Holds the request until taken, then checks the decode
   task automatic cmd(input dpl_req_t r, input logic [1:0] b,
                      input logic [12:0] a, input dpl_cmd_t ex);
      int k;
      req_cmd  <= r;
      req_bank <= b;
      req_addr <= a;
      req_vld  <= 1'b1;
      k = 0;
      do @(posedge clk); while (!req_ack && k++ < 200);
      req_vld <= 1'b0;
      k = 0;
      do @(posedge clk); while (!cmd_stb && k++ < 40);
      `CHK("command", ex, cmd_o)
      repeat (4) @(posedge clk);
   endtask : cmd

   // Leaves valid high so back-to-back pushes need no gap
   task automatic push(input logic [15:0] d, input logic [1:0] m);
      int k;
      wdata <= d;
      wmask <= m;
      wvld  <= 1'b1;
      k = 0;
      do @(posedge clk); while (!wrdy && k++ < 100);
   endtask : push

   task automatic wr(input logic [1:0] b, input logic [12:0] a,
                     input logic [31:0] d, input logic [3:0] m);
      push(d[15:0], m[1:0]);
      push(d[31:16], m[3:2]);
      wvld <= 1'b0;
      cmd(REQ_WRITE, b, a, CMD_WRITE);
   endtask : wr

   task automatic rd(input logic [1:0] b, input logic [12:0] a,
                     input logic [15:0] e0, input logic [15:0] e1);
      int k;
      cmd(REQ_READ, b, a, CMD_READ);
      for (int i = 0; i < 2; i++)
      begin
         k = 0;
         do @(posedge clk); while (!rvld && k++ < 100);
         `CHK("read word", i ? e1 : e0, rdata)
      end
   endtask : rd

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cmd(REQ_ACT, 2'h1, 13'h0000, CMD_ACT);
      `CHK("open banks", 4'h2, bank_open)
      for (int j = 0; j < 32; j++)
         push(16'(j) * 16'h0101, 2'h0);
      wvld <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("buffer full", 1'b0, wrdy)
      for (int j = 0; j < 16; j++)
         cmd(REQ_WRITE, 2'h1, 13'(2 * j), CMD_WRITE);
      `CHK("buffer drained", 1'b1, wrdy)
      rd(2'h1, 13'h0006, 16'h1616, 16'h1717);
      wr(2'h1, 13'h0008, 32'h2222_1111, 4'h0);
      wr(2'h1, 13'h0008, 32'hBBBB_AAAA, 4'h6);
      rd(2'h1, 13'h0408, 16'h11AA, 16'hBB22);
      repeat (20) @(posedge clk);
      `CHK("auto close", 4'h0, bank_open)
      suspend <= 1'b1;
      repeat (40) @(posedge clk);
      `CHK("suspended", 1'b1, susp)
      suspend <= 1'b0;
      repeat (40) @(posedge clk);
      `CHK("resumed", 1'b0, susp)
      cmd(REQ_ACT, 2'h0, 13'h0000, CMD_ACT);
      cmd(REQ_ACT, 2'h2, 13'h0000, CMD_ACT);
      cmd(REQ_CLOSE, 2'h0, 13'h0000, CMD_CLOSE);
      `CHK("one bank closed", 4'h4, bank_open)
      cmd(REQ_CLOSE, 2'h3, 13'h0400, CMD_CLOSE);
      `CHK("all banks closed", 4'h0, bank_open)
      cmd(REQ_READ, 2'h1, 13'h0000, CMD_READ);
      n = 0;
      repeat (150) @(posedge clk) n += int'(rvld);
      `CHK("closed bank beats", 0, n)
      give_verdict();
   end

   initial
   begin
      repeat (30000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule : tb_ddr_command_and_data_lane_pins
